// File: logic/fmc_top.sv
// Flash mode control: address mapping, control registers, mode outputs and boot rate detection
//
// Contract
// - Flash array occupies CPU addresses 0x0000 through 0x7FFF.
// - Mode pins: 00 illegal, 01 external memory, 10 and 11 on-chip flash.
// - Flash reads, byte or word, over a 16-bit path complete in two states.
// - Mode-control and block-select registers reachable only with programming level present.
// - Mode 2 without programming level: control addresses are external space.
// - Mode 3 without programming level: control writes ignored, reads return 0xFF.
// - Mode 1: control writes ignored, reads return 0xFF.
// - Initial values in modes 2 and 3: mode 0x00, small 0x00, large 0xF0.
// - Mode-control clears on reset, standby, absent level; reads 0x80 with level.
// - Mode-control bit 7 is a read-only flag showing the programming level.
// - Mode-control bits 6 to 4 are unwritable and read zero.
// - Bit 3 written 1 enters erase-verify, written 0 leaves it.
// - Bit 2 written 1 enters program-verify, written 0 leaves it.
// - Bit 1 written 1 enters erase, written 0 leaves it.
// - Bit 0 written 1 enters program, written 0 leaves it.
// - Four large and eight small erase blocks, each chosen by a register bit.
// - Boot mode matches its serial bit rate to the host, up to 9600 bps.
// - Large-block register resets to 0xF0 on reset, standby, absent level.
// - Exactly one overlay bit set blocks program and erase, verify still allowed.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "fmc_map.svh"

module fmc_top
  import fmc_pkg::*;
#(
  parameter logic [19:0] BOOT_MIN_LOW_CYC = 20'(`FMC_BOOT_MIN_LOW_CYC)
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register bus
  input wire logic [`FMC_AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`FMC_AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Mode pins, supply detect and standby
  input wire logic op_mode_pin_high,
  input wire logic op_mode_pin_low,
  input wire logic programming_supply_pin,
  input wire logic standby_req,
  // CPU access to the low memory area
  input wire logic cpu_req,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_word,
  output logic cpu_flash_cs,
  output logic cpu_ext_cs,
  output logic cpu_word_lane,
  output logic cpu_ack,
  // Boot serial channel
  input wire logic boot_mode_req,
  input wire logic boot_rxd,
  output logic [15:0] boot_bit_div,
  output logic boot_rate_locked,
  // Array mode and status outputs
  output logic program_mode,
  output logic erase_mode,
  output logic program_verify_mode,
  output logic erase_verify_mode,
  output logic mode_conflict,
  output logic mode_illegal,
  output logic [3:0] large_block_armed,
  output logic [7:0] small_block_armed
);

  fmc_reg_req_s reg_req;
  fmc_reg_rsp_s reg_rsp;

  logic [1:0] op_mode_q;
  logic programming_level_flag_q;
  logic [3:0] mode_bits_q;
  logic [3:0] large_sel_q;
  logic [7:0] small_sel_q;
  logic [7:0] wait_ovl_q;
  logic flash_en;
  logic ctrl_open;
  logic ctrl_as_ext;
  logic ctrl_clear;
  logic overlay_protect;
  logic one_mode;
  logic wr_byte;
  logic wr_ctrl_range;
  logic rd_ctrl_range;
  logic [7:0] rd_byte;

  fmc_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_req(reg_req),
    .reg_rsp(reg_rsp)
  );

  // Pins sampled each cycle so all decode works on one registered view
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_mode_q <= `FMC_MODE_ILLEGAL;
      programming_level_flag_q <= 1'b0;
    end else begin
      op_mode_q <= {op_mode_pin_high, op_mode_pin_low};
      programming_level_flag_q <= programming_supply_pin;
    end
  end

  assign flash_en = (op_mode_q == `FMC_MODE_FLASH2) || (op_mode_q == `FMC_MODE_FLASH3);
  assign ctrl_open = flash_en && programming_level_flag_q;
  assign ctrl_as_ext = (op_mode_q == `FMC_MODE_FLASH2) && !programming_level_flag_q;
  assign ctrl_clear = standby_req || !programming_level_flag_q;
  assign overlay_protect = wait_ovl_q[`FMC_BIT_OVL_SEL] ^ wait_ovl_q[`FMC_BIT_OVL_VAR];
  assign one_mode = $onehot0(mode_bits_q);
  assign wr_byte = reg_req.wr_en && reg_req.wr_strb[0];
  assign wr_ctrl_range = (reg_req.wr_idx >= `FMC_IDX_CTRL_LO) && (reg_req.wr_idx <= `FMC_IDX_CTRL_HI);
  assign rd_ctrl_range = (reg_req.rd_idx >= `FMC_IDX_CTRL_LO) && (reg_req.rd_idx <= `FMC_IDX_CTRL_HI);

  // Only the four mode bits are stored; the flag and reserved bits are composed on read
  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl_clear) begin
      mode_bits_q <= 4'(`FMC_RST_MODE_CTRL);
    end else if (wr_byte && ctrl_open && reg_req.wr_idx == `FMC_IDX_MODE_CTRL) begin
      mode_bits_q <= reg_req.wr_data[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl_clear) begin
      large_sel_q <= 4'(`FMC_RST_LARGE_SEL);
    end else if (wr_byte && ctrl_open && reg_req.wr_idx == `FMC_IDX_LARGE_SEL) begin
      large_sel_q <= reg_req.wr_data[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl_clear) begin
      small_sel_q <= `FMC_RST_SMALL_SEL;
    end else if (wr_byte && ctrl_open && reg_req.wr_idx == `FMC_IDX_SMALL_SEL) begin
      small_sel_q <= reg_req.wr_data[7:0];
    end
  end

  // Overlay control survives standby and supply loss; only reset reloads it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_ovl_q <= `FMC_RST_WAIT_OVL;
    end else if (wr_byte && reg_req.wr_idx == `FMC_IDX_WAIT_OVL) begin
      wait_ovl_q <= reg_req.wr_data[7:0];
    end
  end

  // Read data and responses
  always_comb begin
    rd_byte = `FMC_RSVD_READ;
    reg_rsp.rd_resp = `FMC_RESP_OKAY;
    reg_rsp.wr_resp = `FMC_RESP_OKAY;
    if (rd_ctrl_range) begin
      if (ctrl_as_ext) begin
        reg_rsp.rd_resp = `FMC_RESP_DECERR;
      end else if (!ctrl_open) begin
        rd_byte = `FMC_BLOCKED_READ;
      end else begin
        case (reg_req.rd_idx)
          `FMC_IDX_MODE_CTRL: begin
            rd_byte = {programming_level_flag_q, 3'h0, mode_bits_q};
          end
          `FMC_IDX_LARGE_SEL: begin
            rd_byte = `FMC_LARGE_FIXED | {4'h0, large_sel_q};
          end
          `FMC_IDX_SMALL_SEL: begin
            rd_byte = small_sel_q;
          end
          default: begin
            rd_byte = `FMC_RSVD_READ;
          end
        endcase
      end
    end else if (reg_req.rd_idx == `FMC_IDX_WAIT_OVL) begin
      rd_byte = wait_ovl_q;
    end else begin
      reg_rsp.rd_resp = `FMC_RESP_DECERR;
    end
    if (wr_ctrl_range) begin
      if (ctrl_as_ext) begin
        reg_rsp.wr_resp = `FMC_RESP_DECERR;
      end
    end else if (reg_req.wr_idx != `FMC_IDX_WAIT_OVL) begin
      reg_rsp.wr_resp = `FMC_RESP_DECERR;
    end
    reg_rsp.rd_data = {24'h000000, rd_byte};
  end

  // Array modes; a conflicting bit pattern runs no mode rather than guess a priority
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_mode <= 1'b0;
      erase_mode <= 1'b0;
      program_verify_mode <= 1'b0;
      erase_verify_mode <= 1'b0;
      mode_conflict <= 1'b0;
      mode_illegal <= 1'b0;
    end else begin
      program_mode <= mode_bits_q[`FMC_BIT_P] && one_mode && ctrl_open && !ctrl_clear && !overlay_protect;
      erase_mode <= mode_bits_q[`FMC_BIT_E] && one_mode && ctrl_open && !ctrl_clear && !overlay_protect;
      program_verify_mode <= mode_bits_q[`FMC_BIT_PV] && one_mode && ctrl_open && !ctrl_clear;
      erase_verify_mode <= mode_bits_q[`FMC_BIT_EV] && one_mode && ctrl_open && !ctrl_clear;
      mode_conflict <= !one_mode;
      mode_illegal <= (op_mode_q == `FMC_MODE_ILLEGAL);
    end
  end

  // One select bit per erase block; a block is armed only in the cycle after one in which program or erase runs
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_block
      if (gi < 4) begin : g_large
        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            large_block_armed[gi] <= 1'b0;
          end else begin
            large_block_armed[gi] <= large_sel_q[gi] && (program_mode || erase_mode);
          end
        end
      end else begin : g_small
        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            small_block_armed[gi-4] <= 1'b0;
          end else begin
            small_block_armed[gi-4] <= small_sel_q[gi-4] && (program_mode || erase_mode);
          end
        end
      end
    end
  endgenerate

  // CPU access to the low area
  fmc_acc_state_e acc_state_q;
  logic [1:0] acc_cnt_q;
  logic cpu_in_flash;
  logic cpu_in_ctrl;

  assign cpu_in_flash = (cpu_addr >= `FMC_FLASH_LO) && (cpu_addr <= `FMC_FLASH_HI);
  assign cpu_in_ctrl = (cpu_addr >= `FMC_IDX_CTRL_LO) && (cpu_addr <= `FMC_IDX_CTRL_HI);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_state_q <= ACC_IDLE;
      acc_cnt_q <= 2'h0;
      cpu_flash_cs <= 1'b0;
      cpu_ext_cs <= 1'b0;
      cpu_word_lane <= 1'b0;
      cpu_ack <= 1'b0;
    end else begin
      cpu_ack <= 1'b0;
      case (acc_state_q)
        ACC_IDLE: begin
          if (cpu_req) begin
            acc_state_q <= ACC_BUSY;
            acc_cnt_q <= 2'h0;
            cpu_flash_cs <= cpu_in_flash && flash_en;
            cpu_ext_cs <= (cpu_in_flash && !flash_en) || (cpu_in_ctrl && ctrl_as_ext);
            cpu_word_lane <= cpu_word;
          end
        end
        ACC_BUSY: begin
          if (acc_cnt_q == `FMC_ACCESS_STATES - 2'h1) begin
            acc_state_q <= ACC_IDLE;
            acc_cnt_q <= 2'h0;
            cpu_flash_cs <= 1'b0;
            cpu_ext_cs <= 1'b0;
            cpu_ack <= 1'b1;
          end else begin
            acc_cnt_q <= acc_cnt_q + 2'h1;
          end
        end
        default: begin
          acc_state_q <= ACC_IDLE;
        end
      endcase
    end
  end

  // Boot rate: time the low run of the host's zero byte, then divide by nine bit times
  fmc_ab_state_e ab_state_q;
  logic [19:0] ab_cnt_q;
  logic rxd_q;
  logic [25:0] ab_prod;

  assign ab_prod = 26'(ab_cnt_q) * `FMC_DIV9_MUL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_q <= 1'b1;
    end else begin
      rxd_q <= boot_rxd;
    end
  end

  // Runs shorter than the fastest allowed rate are rejected as noise and measurement restarts
  always_ff @(posedge aclk) begin
    if (!aresetn || !boot_mode_req) begin
      ab_state_q <= AB_IDLE;
      ab_cnt_q <= 20'h00000;
      boot_bit_div <= 16'h0000;
      boot_rate_locked <= 1'b0;
    end else begin
      case (ab_state_q)
        AB_IDLE: begin
          if (rxd_q && !boot_rxd) begin
            ab_state_q <= AB_LOW;
            ab_cnt_q <= 20'h00001;
          end
        end
        AB_LOW: begin
          if (boot_rxd) begin
            if (ab_cnt_q >= BOOT_MIN_LOW_CYC) begin
              ab_state_q <= AB_DONE;
              boot_bit_div <= ab_prod[25] ? 16'hFFFF : ab_prod[24:`FMC_DIV9_SHIFT];
              boot_rate_locked <= 1'b1;
            end else begin
              ab_state_q <= AB_IDLE;
            end
          end else if (ab_cnt_q != 20'hFFFFF) begin
            ab_cnt_q <= ab_cnt_q + 20'h00001;
          end
        end
        AB_DONE: begin
          ab_state_q <= AB_DONE;
        end
        default: begin
          ab_state_q <= AB_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// File: logic/fmc_map.svh
// Register indices, field positions, reset values and timing counts of the flash mode control block
`ifndef FMC_MAP_SVH
`define FMC_MAP_SVH

// Register indices; the byte address on the bus is four times the index
`define FMC_IDX_MODE_CTRL 16'hFF80
`define FMC_IDX_LARGE_SEL 16'hFF82
`define FMC_IDX_SMALL_SEL 16'hFF83
`define FMC_IDX_WAIT_OVL 16'hFFC2
`define FMC_IDX_CTRL_LO 16'hFF80
`define FMC_IDX_CTRL_HI 16'hFF83
`define FMC_AXI_ADDR_W 18

// Reset values and fixed read values
`define FMC_RST_MODE_CTRL 8'h00
`define FMC_RST_MODE_CTRL_VPP 8'h80
`define FMC_RST_LARGE_SEL 8'hF0
`define FMC_RST_SMALL_SEL 8'h00
`define FMC_RST_WAIT_OVL 8'h08
`define FMC_LARGE_FIXED 8'hF0
`define FMC_BLOCKED_READ 8'hFF
`define FMC_RSVD_READ 8'h00

// Field positions in the mode control register
`define FMC_BIT_VPP 7
`define FMC_BIT_EV 3
`define FMC_BIT_PV 2
`define FMC_BIT_E 1
`define FMC_BIT_P 0

// Field positions in the wait and overlay control register
`define FMC_BIT_OVL_SEL 7
`define FMC_BIT_OVL_VAR 6

// Operating-mode pin codes
`define FMC_MODE_ILLEGAL 2'b00
`define FMC_MODE_EXT 2'b01
`define FMC_MODE_FLASH2 2'b10
`define FMC_MODE_FLASH3 2'b11

// Flash array window in the CPU address space
`define FMC_FLASH_LO 16'h0000
`define FMC_FLASH_HI 16'h7FFF

// CPU access length in states
`define FMC_ACCESS_STATES 2'h2

// Boot rate measurement: host sends a zero byte, start bit plus eight data bits low
`define FMC_CLK_HZ 25000000
`define FMC_BOOT_MAX_BPS 9600
`define FMC_BOOT_LOW_BITS 9
`define FMC_BOOT_MIN_BIT_CYC (`FMC_CLK_HZ / `FMC_BOOT_MAX_BPS)
`define FMC_BOOT_MIN_LOW_CYC (`FMC_BOOT_MIN_BIT_CYC * `FMC_BOOT_LOW_BITS)
`define FMC_DIV9_MUL 26'h0000039
`define FMC_DIV9_SHIFT 9

// AXI responses
`define FMC_RESP_OKAY 2'b00
`define FMC_RESP_DECERR 2'b11

`endif

// File: logic/fmc_pkg.sv
// Types shared by the flash mode control block and its bus slave
package fmc_pkg;

  typedef struct packed {
    logic wr_en;
    logic [15:0] wr_idx;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic rd_en;
    logic [15:0] rd_idx;
  } fmc_reg_req_s;

  typedef struct packed {
    logic [1:0] wr_resp;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
  } fmc_reg_rsp_s;

  typedef enum logic [1:0] {
    AB_IDLE,
    AB_LOW,
    AB_DONE
  } fmc_ab_state_e;

  typedef enum logic {
    ACC_IDLE,
    ACC_BUSY
  } fmc_acc_state_e;

endpackage

// File: logic/fmc_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into one-cycle register requests
`timescale 1ns/1ps
`default_nettype none
`include "fmc_map.svh"

module fmc_axil_slave
  import fmc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [`FMC_AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [`FMC_AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output fmc_reg_req_s reg_req,
  input wire fmc_reg_rsp_s reg_rsp
);

  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [15:0] aw_idx_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [15:0] ar_idx_q;
  logic wr_go;
  logic rd_go;

  // A dropped ready means that half of the transfer is held
  assign wr_go = !awready_q && !wready_q && !bvalid_q;
  assign rd_go = !arready_q && !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_idx_q <= 16'h0000;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_idx_q <= s_axi_awaddr[17:2];
    end else if (wr_go) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `FMC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= reg_rsp.wr_resp;
    end else if (s_axi_bready && bvalid_q) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      ar_idx_q <= 16'h0000;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      ar_idx_q <= s_axi_araddr[17:2];
    end else if (rd_go) begin
      arready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= `FMC_RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= reg_rsp.rd_resp;
      rdata_q <= reg_rsp.rd_data;
    end else if (s_axi_rready && rvalid_q) begin
      rvalid_q <= 1'b0;
    end
  end

  always_comb begin
    reg_req.wr_en = wr_go;
    reg_req.wr_idx = aw_idx_q;
    reg_req.wr_data = w_data_q;
    reg_req.wr_strb = w_strb_q;
    reg_req.rd_en = rd_go;
    reg_req.rd_idx = ar_idx_q;
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

endmodule

`default_nettype wire

// File: dv/fmc_top_checker.sv
// Concurrent checks on the ports of the flash mode control top
`timescale 1ns/1ps
`default_nettype none
module fmc_top_checker (
  // Clock, reset and pins
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic op_mode_pin_high,
  input wire logic op_mode_pin_low,
  input wire logic programming_supply_pin,
  input wire logic standby_req,
  // Bus write handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  // CPU port and modes
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_flash_cs,
  input wire logic cpu_ext_cs,
  input wire logic cpu_ack,
  input wire logic program_mode,
  input wire logic erase_mode,
  input wire logic program_verify_mode,
  input wire logic erase_verify_mode,
  input wire logic mode_illegal
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_ONE_MODE: assert property ($onehot0({program_mode, erase_mode, program_verify_mode, erase_verify_mode}))
    else $error("several modes active");
  // Pin flops add latency, so four low samples are allowed before modes must be gone
  AST_NO_LEVEL: assert property (!programming_supply_pin [*4] |-> !program_mode && !erase_mode)
    else $error("program or erase without level");
  AST_STANDBY: assert property (standby_req [*4] |-> !(program_mode | erase_mode | program_verify_mode
    | erase_verify_mode))
    else $error("mode active in standby");
  AST_CS_LEN: assert property ($rose(cpu_flash_cs) |=> cpu_flash_cs ##1 !cpu_flash_cs && cpu_ack)
    else $error("flash access not two states");
  AST_EXT_LEN: assert property ($rose(cpu_ext_cs) |=> cpu_ext_cs ##1 !cpu_ext_cs && cpu_ack)
    else $error("external access not two states");
  AST_FLASH_MAP: assert property ($rose(cpu_flash_cs) |-> op_mode_pin_high && $past(cpu_addr) <= 16'h7FFF)
    else $error("flash selected outside its window");
  AST_EXT_MAP: assert property ($rose(cpu_ext_cs) |-> (!op_mode_pin_high && $past(cpu_addr) <= 16'h7FFF)
    || (!programming_supply_pin && $past(cpu_addr[15:2]) == 14'h3FE0))
    else $error("external select without cause");
  AST_ILLEGAL: assert property ((!op_mode_pin_high && !op_mode_pin_low) [*3] |-> mode_illegal)
    else $error("illegal pins not flagged");
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  cover property (program_mode);
  cover property ($rose(cpu_ext_cs));
  cover property (mode_illegal);
endmodule
`default_nettype wire

// File: dv/fmc_cpu_model.sv
// CPU-side model issuing low-memory accesses
`timescale 1ns/1ps
`default_nettype none
module fmc_cpu_model (
  // Clock
  input wire logic aclk,
  // Request
  output logic cpu_req,
  output logic [15:0] cpu_addr,
  output logic cpu_word,
  // Answer
  input wire logic cpu_flash_cs,
  input wire logic cpu_ext_cs,
  input wire logic cpu_ack
);
  initial begin
    cpu_req = 1'b0;
    cpu_addr = 16'h0000;
    cpu_word = 1'b0;
  end
  // Counts edges to ack and the cycles each select stood
  task automatic access(input logic [15:0] a, input logic w, output int n, output int nf, output int ne);
    n = 0;
    nf = 0;
    ne = 0;
    cpu_addr <= a;
    cpu_word <= w;
    cpu_req <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      cpu_req <= 1'b0;
      // Address is not held once taken, so a stale value cannot pass
      cpu_addr <= ~a;
      nf += int'(cpu_flash_cs);
      ne += int'(cpu_ext_cs);
    end while (!cpu_ack && n < 50);
  endtask
endmodule
`default_nettype wire

// File: dv/fmc_top_bench.sv
// Self-checking bench for the flash mode control top
`timescale 1ns/1ps
`default_nettype none
`include "fmc_map.svh"
module fmc_top_bench;
  import fmc_pkg::*;
  localparam logic [15:0] MC = `FMC_IDX_MODE_CTRL;
  localparam logic [15:0] LS = `FMC_IDX_LARGE_SEL;
  localparam logic [15:0] SS = `FMC_IDX_SMALL_SEL;
  localparam logic [15:0] WO = `FMC_IDX_WAIT_OVL;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, op_mode_pin_high = 1'b1, op_mode_pin_low = 1'b0;
  logic programming_supply_pin = 1'b1, standby_req = 1'b0, boot_mode_req = 1'b0, boot_rxd = 1'b1;
  logic [`FMC_AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, large_block_armed;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_req, cpu_word;
  logic cpu_flash_cs, cpu_ext_cs, cpu_word_lane, cpu_ack, boot_rate_locked, program_mode, erase_mode;
  logic program_verify_mode, erase_verify_mode, mode_conflict, mode_illegal;
  logic [15:0] cpu_addr, boot_bit_div;
  logic [7:0] small_block_armed;
  int mismatches = 0;
  int n_checks = 0;
  initial forever #20 aclk = ~aclk;
  fmc_top #(.BOOT_MIN_LOW_CYC(20'h00014)) fmc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .op_mode_pin_high, .op_mode_pin_low, .programming_supply_pin, .standby_req, .cpu_req,
    .cpu_addr, .cpu_word, .cpu_flash_cs, .cpu_ext_cs, .cpu_word_lane, .cpu_ack, .boot_mode_req, .boot_rxd,
    .boot_bit_div, .boot_rate_locked, .program_mode, .erase_mode, .program_verify_mode, .erase_verify_mode,
    .mode_conflict, .mode_illegal, .large_block_armed, .small_block_armed);
  fmc_cpu_model fmc_cpu_model_inst (.aclk, .cpu_req, .cpu_addr, .cpu_word, .cpu_flash_cs, .cpu_ext_cs, .cpu_ack);
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic hang();
    mismatches++;
    stop_test();
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] r = 2'b00);
    int n;
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    if (n == 50) hang();
    else chk(34'(s_axi_bresp), 34'(r));
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] d, input logic [1:0] r = 2'b00);
    int n;
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    if (n == 50) hang();
    else chk({s_axi_rresp, s_axi_rdata}, {r, 24'h000000, d});
  endtask
  task automatic md(input logic [3:0] e);
    repeat (2) @(posedge aclk);
    chk(34'({erase_verify_mode, program_verify_mode, erase_mode, program_mode}), 34'(e));
  endtask
  task automatic pins(input logic [1:0] m, input logic v);
    {op_mode_pin_high, op_mode_pin_low} <= m;
    programming_supply_pin <= v;
    repeat (4) @(posedge aclk);
  endtask
  // Word access; four edges to ack with the select up for two of them
  task automatic cpu(input logic [15:0] a, input int f, input int x);
    int n, nf, ne;
    fmc_cpu_model_inst.access(a, 1'b1, n, nf, ne);
    if (n == 50) hang();
    else chk(34'({n[7:0], nf[7:0], ne[7:0], 7'h00, cpu_word_lane}), 34'({8'h04, f[7:0], x[7:0], 8'h01}));
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    pins(2'b10, 1'b1);
    rd(MC, 8'h80);
    rd(LS, 8'hF0);
    rd(SS, 8'h00);
    rd(WO, 8'h08);
    rd(16'hFF90, 8'h00, 2'b11);
    for (int i = 0; i < 4; i++) begin
      wr(MC, 8'h70 | 8'(1 << i));
      rd(MC, 8'h80 | 8'(1 << i));
      md(4'(1 << i));
    end
    wr(SS, 8'hA5);
    wr(LS, 8'h05);
    rd(LS, 8'hF5);
    wr(MC, 8'h01);
    md(4'h1);
    chk(34'({large_block_armed, small_block_armed}), 34'(12'h5A5));
    wr(MC, 8'h03);
    md(4'h0);
    chk(34'(mode_conflict), 34'(1'b1));
    wr(WO, 8'h80);
    wr(MC, 8'h01);
    md(4'h0);
    wr(MC, 8'h08);
    md(4'h8);
    wr(WO, 8'hC0);
    wr(MC, 8'h02);
    md(4'h2);
    standby_req <= 1'b1;
    repeat (4) @(posedge aclk);
    md(4'h0);
    standby_req <= 1'b0;
    rd(MC, 8'h80);
    rd(LS, 8'hF0);
    rd(WO, 8'hC0);
    wr(MC, 8'h01);
    pins(2'b10, 1'b0);
    md(4'h0);
    rd(MC, 8'h00, 2'b11);
    wr(SS, 8'hFF, 2'b11);
    cpu(16'h1234, 2, 0);
    cpu(16'hFF81, 0, 2);
    pins(2'b11, 1'b0);
    rd(MC, 8'hFF);
    wr(SS, 8'h12);
    rd(SS, 8'hFF);
    pins(2'b11, 1'b1);
    rd(SS, 8'h00);
    wr(SS, 8'h3C);
    rd(SS, 8'h3C);
    pins(2'b01, 1'b1);
    rd(MC, 8'hFF);
    wr(LS, 8'h00);
    rd(LS, 8'hFF);
    cpu(16'h1234, 0, 2);
    pins(2'b00, 1'b1);
    chk(34'(mode_illegal), 34'(1'b1));
    pins(2'b10, 1'b1);
    boot_mode_req <= 1'b1;
    repeat (3) @(posedge aclk);
    boot_rxd <= 1'b0;
    repeat (40) @(posedge aclk);
    boot_rxd <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(34'({boot_rate_locked, boot_bit_div}), 34'({1'b1, 16'(40 / 9)}));
    stop_test();
  end
endmodule
bind fmc_top fmc_top_checker fmc_top_checker_inst (.aclk, .aresetn, .op_mode_pin_high, .op_mode_pin_low,
  .programming_supply_pin, .standby_req, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .cpu_addr, .cpu_flash_cs, .cpu_ext_cs, .cpu_ack, .program_mode, .erase_mode,
  .program_verify_mode, .erase_verify_mode, .mode_illegal);
`default_nettype wire
